// file: rtl/pcr_top.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
// Notes on behaviour
// RL1: second divider ratio zero holds it in standby; 1 to 127 divide.
// RL2: third divider ratio zero holds it in standby; 1 to 127 divide.
// RL3: software writes zero to reserved bit 7 of third divider byte.
// RL4: first setting word is N, R, Q, P packed msb first in 4 bytes.
// RL5: alternate setting word uses same packing in the next four bytes.
// RL6: first setting 2-bit vco band selects one of four ranges.
// RL7: after reset both settings hold N 4, R 0, Q 16, P 2, band 00.
// RL8: alternate setting band uses the same four-range encoding.
module pcr_top
    import pcr_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire pcr_bus_req_t busReq,
    output logic [7:0] readData,
    output pcr_setting_t set0Setting,
    output pcr_setting_t set1Setting,
    output logic [3:0] set0BandSel,
    output logic [3:0] set1BandSel,
    output logic [PCR_DIV_W-1:0] secondDivRatio,
    output logic [PCR_DIV_W-1:0] thirdDivRatio,
    output logic secondDivStandby,
    output logic thirdDivStandby,
    output logic secondDivTick,
    output logic thirdDivTick
);

    logic [PCR_NUM_BYTES-1:0][7:0] bytes;
    logic hit;
    logic [PCR_IDX_W-1:0] index;
    logic [7:0] offsetDiff;

    // address decode over the window of ten bytes
    assign hit = (busReq.addr >= PCR_BASE_OFFSET) &&
                 (busReq.addr <= PCR_LAST_OFFSET);
    assign offsetDiff = busReq.addr - PCR_BASE_OFFSET;
    assign index = offsetDiff[PCR_IDX_W-1:0];

    // byte storage with reset defaults and registered read
    // RL7: reset defaults
    // RL3: reserved bit dropped
    pcr_byte_store #(
        .NUM(PCR_NUM_BYTES),
        .IW(PCR_IDX_W)
    ) u_store (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .wrEn(busReq.wrStrobe),
        .rdEn(busReq.rdStrobe),
        .hit(hit),
        .index(index),
        .wrData(busReq.wrData),
        .rdData(readData),
        .bytes(bytes)
    );

    // RL4: first setting unpack
    assign set0Setting = {bytes[PCR_IX_SET0], bytes[PCR_IX_SET0+1],
                          bytes[PCR_IX_SET0+2], bytes[PCR_IX_SET0+3]};

    // RL5: alternate setting unpack
    assign set1Setting = {bytes[PCR_IX_SET1], bytes[PCR_IX_SET1+1],
                          bytes[PCR_IX_SET1+2], bytes[PCR_IX_SET1+3]};

    // divider ratios from the low seven bits
    assign secondDivRatio = bytes[PCR_IX_DIV2][PCR_DIV_W-1:0];
    assign thirdDivRatio = bytes[PCR_IX_DIV3][PCR_DIV_W-1:0];

    // one-hot vco range for a band code
    function automatic logic [3:0] band_onehot(input logic [1:0] band);
        logic [3:0] sel;
        sel = 4'h0;
        unique case (band)
            PCR_BAND_LT125: sel = 4'h1;
            PCR_BAND_LT150: sel = 4'h2;
            PCR_BAND_LT175: sel = 4'h4;
            PCR_BAND_GE175: sel = 4'h8;
        endcase
        return sel;
    endfunction

    // RL6: first band select
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            set0BandSel <= 4'h1;
        end else if (ce) begin
            set0BandSel <= band_onehot(set0Setting.vcoBand);
        end
    end

    // RL8: alternate band select
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            set1BandSel <= 4'h1;
        end else if (ce) begin
            set1BandSel <= band_onehot(set1Setting.vcoBand);
        end
    end

    // RL1: second divider
    pcr_out_divider #(
        .W(PCR_DIV_W)
    ) u_div2 (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .ratio(secondDivRatio),
        .tick(secondDivTick),
        .standby(secondDivStandby)
    );

    // RL2: third divider
    pcr_out_divider #(
        .W(PCR_DIV_W)
    ) u_div3 (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .ratio(thirdDivRatio),
        .tick(thirdDivTick),
        .standby(thirdDivStandby)
    );

endmodule

// file: rtl/pcr_pkg.sv
package pcr_pkg;

    // register window: second output divider up to the alternate setting
    localparam int PCR_NUM_BYTES = 10;
    localparam int PCR_IDX_W = 4;
    localparam int PCR_DIV_W = 7;
    localparam logic [7:0] PCR_BASE_OFFSET = 8'h16;
    localparam logic [7:0] PCR_LAST_OFFSET = 8'h1F;

    // byte offsets
    localparam logic [7:0] PCR_OFS_DIV2 = 8'h16;
    localparam logic [7:0] PCR_OFS_DIV3 = 8'h17;
    localparam logic [7:0] PCR_OFS_SET0_B0 = 8'h18;
    localparam logic [7:0] PCR_OFS_SET0_B1 = 8'h19;
    localparam logic [7:0] PCR_OFS_SET0_B2 = 8'h1A;
    localparam logic [7:0] PCR_OFS_SET0_B3 = 8'h1B;
    localparam logic [7:0] PCR_OFS_SET1_B0 = 8'h1C;
    localparam logic [7:0] PCR_OFS_SET1_B1 = 8'h1D;
    localparam logic [7:0] PCR_OFS_SET1_B2 = 8'h1E;
    localparam logic [7:0] PCR_OFS_SET1_B3 = 8'h1F;

    // store indices of the bytes (offset minus base)
    localparam int PCR_IX_DIV2 = 0;
    localparam int PCR_IX_DIV3 = 1;
    localparam int PCR_IX_SET0 = 2;
    localparam int PCR_IX_SET1 = 6;

    // reset values: dividers at 1, settings N=4 R=0 Q=16 P=2 band 00
    localparam logic [7:0] PCR_RST_DIV = 8'h01;
    localparam logic [7:0] PCR_RST_SET_B0 = 8'h00;
    localparam logic [7:0] PCR_RST_SET_B1 = 8'h40;
    localparam logic [7:0] PCR_RST_SET_B2 = 8'h02;
    localparam logic [7:0] PCR_RST_SET_B3 = 8'h08;

    // writable bits; bit 7 of the third divider byte is reserved
    localparam logic [7:0] PCR_MASK_ALL = 8'hFF;
    localparam logic [7:0] PCR_MASK_DIV3 = 8'h7F;

    // reset and mask tables, entry 0 at the base offset
    localparam logic [PCR_NUM_BYTES-1:0][7:0] PCR_RST_TABLE = {
        PCR_RST_SET_B3, PCR_RST_SET_B2, PCR_RST_SET_B1, PCR_RST_SET_B0,
        PCR_RST_SET_B3, PCR_RST_SET_B2, PCR_RST_SET_B1, PCR_RST_SET_B0,
        PCR_RST_DIV, PCR_RST_DIV};
    localparam logic [PCR_NUM_BYTES-1:0][7:0] PCR_MASK_TABLE = {
        PCR_MASK_ALL, PCR_MASK_ALL, PCR_MASK_ALL, PCR_MASK_ALL,
        PCR_MASK_ALL, PCR_MASK_ALL, PCR_MASK_ALL, PCR_MASK_ALL,
        PCR_MASK_DIV3, PCR_MASK_ALL};

    // vco band codes
    localparam logic [1:0] PCR_BAND_LT125 = 2'h0;
    localparam logic [1:0] PCR_BAND_LT150 = 2'h1;
    localparam logic [1:0] PCR_BAND_LT175 = 2'h2;
    localparam logic [1:0] PCR_BAND_GE175 = 2'h3;

    // register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wrData;
        logic wrStrobe;
        logic rdStrobe;
    } pcr_bus_req_t;

    // one pll setting, most significant field first as in the bytes
    typedef struct packed {
        logic [11:0] nField;
        logic [8:0] rField;
        logic [5:0] qField;
        logic [2:0] pField;
        logic [1:0] vcoBand;
    } pcr_setting_t;

endpackage

// file: rtl/pcr_byte_store.sv
`timescale 1ns/100ps
module pcr_byte_store
    import pcr_pkg::*;
#(
    parameter int NUM = PCR_NUM_BYTES,
    parameter int IW = PCR_IDX_W
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic wrEn,
    input wire logic rdEn,
    input wire logic hit,
    input wire logic [IW-1:0] index,
    input wire logic [7:0] wrData,
    output logic [7:0] rdData,
    output logic [NUM-1:0][7:0] bytes
);

    // one byte register per entry, masked writes
    genvar i;
    generate
        for (i = 0; i < NUM; i++) begin : g_byte
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    bytes[i] <= PCR_RST_TABLE[i];
                end else if (ce && wrEn && hit && index == IW'(i)) begin
                    bytes[i] <= wrData & PCR_MASK_TABLE[i];
                end
            end
        end
    endgenerate

    // registered read, zero for a miss or no read
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdData <= 8'h00;
        end else if (ce) begin
            rdData <= (rdEn && hit) ? bytes[index] : 8'h00;
        end
    end

endmodule

// file: rtl/pcr_out_divider.sv
`timescale 1ns/100ps
module pcr_out_divider
    import pcr_pkg::*;
#(
    parameter int W = PCR_DIV_W
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic [W-1:0] ratio,
    output logic tick,
    output logic standby
);

    logic [W-1:0] count_reg;
    logic atEnd;
    logic idle;

    assign idle = (ratio == '0);
    assign atEnd = !idle && (count_reg >= ratio - W'(1));

    // cycle counter, held at zero while the ratio is zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
        end else if (ce) begin
            if (idle || atEnd) begin
                count_reg <= '0;
            end else begin
                count_reg <= count_reg + W'(1);
            end
        end
    end

    // one pulse every ratio cycles, standby flag while idle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tick <= 1'b0;
            standby <= 1'b1;
        end else if (ce) begin
            tick <= atEnd;
            standby <= idle;
        end
    end

endmodule

// file: test/pcr_top_chk.sv
`timescale 1ns/100ps
module pcr_top_chk
    import pcr_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire pcr_bus_req_t busReq,
    input wire logic [7:0] readData,
    input wire pcr_setting_t set0Setting,
    input wire pcr_setting_t set1Setting,
    input wire logic [3:0] set0BandSel,
    input wire logic [3:0] set1BandSel,
    input wire logic [PCR_DIV_W-1:0] secondDivRatio,
    input wire logic [PCR_DIV_W-1:0] thirdDivRatio
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // a write taken at this edge
    sequence wrAt(a);
        ce && busReq.wrStrobe && busReq.addr == a;
    endsequence
    // a read taken at this edge
    sequence rdAt(a);
        ce && busReq.rdStrobe && busReq.addr == a;
    endsequence
    a_div3_resv: assert property (
        rdAt(8'h17) |=> readData[7] == 1'b0) else $error("bit 7 set");
    a_div2_ratio: assert property (
        wrAt(8'h16) |=> secondDivRatio == $past(busReq.wrData[6:0]))
        else $error("ratio 2");
    a_div3_ratio: assert property (
        wrAt(8'h17) |=> thirdDivRatio == $past(busReq.wrData[6:0]))
        else $error("ratio 3");
    a_set0_low: assert property (
        wrAt(8'h1B) |=> set0Setting[7:0] == $past(busReq.wrData))
        else $error("set0 byte");
    a_set1_high: assert property (
        wrAt(8'h1C) |=> set1Setting[31:24] == $past(busReq.wrData))
        else $error("set1 byte");
    a_band0_decode: assert property (
        ce |=> set0BandSel == 4'h1 << $past(set0Setting.vcoBand))
        else $error("band0");
    a_band1_decode: assert property (
        ce |=> set1BandSel == 4'h1 << $past(set1Setting.vcoBand))
        else $error("band1");
    a_read_idle: assert property (
        ce && !busReq.rdStrobe |=> readData == 8'h00) else $error("idle");
endmodule
bind pcr_top pcr_top_chk u_chk (.*);

// file: test/pcr_top_tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
    num_errors++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module pcr_top_tb
    import pcr_pkg::*;
;
    logic clock = 0, rst = 1, ce = 1;
    pcr_bus_req_t busReq = '0;
    logic [7:0] readData;
    pcr_setting_t set0Setting, set1Setting;
    logic [3:0] set0BandSel, set1BandSel;
    logic [6:0] secondDivRatio, thirdDivRatio;
    logic secondDivStandby, thirdDivStandby, secondDivTick, thirdDivTick;
    int num_errors = 0, num_checks = 0, seed = 32'h0330_54a0;
    logic [7:0] m [22:31];
    logic [31:0] w;
    logic [7:0] d;
    pcr_top u_dut (.*);
    always #5 clock = ~clock;
    // one write cycle, mirrored in the model
    task automatic wr(logic [7:0] a, logic [7:0] v);
        @(posedge clock);
        busReq <= '{a, v, 1'b1, 1'b0};
        @(posedge clock);
        busReq <= '0;
        if (a >= 8'h16 && a <= 8'h1F)
            m[a] = a == 8'h17 ? v & 8'h7F : v;
        #1 `CHK(set0Setting, {m[24], m[25], m[26], m[27]})
        `CHK(set1Setting, {m[28], m[29], m[30], m[31]})
    endtask
    // one read cycle, data sampled in the following cycle
    task automatic rd(logic [7:0] a);
        @(posedge clock);
        busReq <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock);
        busReq <= '0;
        #1 `CHK(readData, a >= 8'h16 && a <= 8'h1F ? m[a] : 8'h00)
    endtask
    // set both ratios, then count ticks over eight periods
    task automatic divs(int r);
        int c2, c3;
        c2 = 0;
        c3 = 0;
        wr(8'h16, 8'(r));
        wr(8'h17, 8'(r));
        repeat (260) @(posedge clock);
        repeat (r ? r * 8 : 40) begin
            @(posedge clock);
            #1 c2 += secondDivTick;
            c3 += thirdDivTick;
        end
        `CHK(c2, r ? 8 : 0)
        `CHK(c3, r ? 8 : 0)
        `CHK(secondDivStandby, r == 0)
        `CHK(thirdDivStandby, r == 0)
        $display("divider test r=%0d done", r);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        #300000;
        num_errors++;
        final_report();
    end
    // main sequence
    initial begin
        w = {12'h004, 9'h000, 6'h10, 3'h2, 2'h0};
        for (int a = 22; a < 32; a++)
            m[a] = a < 24 ? 8'h01 : w[8 * (3 - a % 4) +: 8];
        repeat (6) @(posedge clock);
        rst <= 0;
        #1 `CHK(set0Setting, w)
        `CHK(set1Setting, w)
        `CHK(set0BandSel, 4'h1)
        `CHK(secondDivStandby, 1'b1)
        for (int a = 8'h14; a < 8'h22; a++)
            rd(8'(a));
        $display("reset test done");
        repeat (2) begin
            for (int a = 8'h14; a < 8'h22; a++) begin
                d = 8'($random(seed));
                if (a == 8'h17) d[7] = 1'b0;
                wr(8'(a), d);
                rd(8'(a));
            end
        end
        $display("random test done");
        for (int c = 0; c < 4; c++) begin
            wr(8'h1B, m[27] & 8'hFC | 8'(c));
            wr(8'h1F, m[31] & 8'hFC | 8'(c));
            @(posedge clock);
            #1 `CHK(set0BandSel, 4'h1 << c)
            `CHK(set1BandSel, 4'h1 << c)
        end
        $display("band test done");
        // write then read with no gap, then hold the enable low
        d = 8'($random(seed));
        @(posedge clock);
        busReq <= '{8'h1E, d, 1'b1, 1'b0};
        @(posedge clock);
        busReq <= '{8'h1E, 8'h00, 1'b0, 1'b1};
        m[30] = d;
        @(posedge clock);
        busReq <= '{8'h1C, 8'h5A, 1'b1, 1'b0};
        ce <= 1'b0;
        #1 `CHK(readData, m[30])
        @(posedge clock);
        busReq <= '0;
        @(posedge clock);
        ce <= 1'b1;
        #1 `CHK(readData, m[30])
        `CHK(set1Setting, {m[28], m[29], m[30], m[31]})
        $display("freeze test done");
        divs(0);
        divs(1);
        divs(2);
        divs(127);
        divs(1 + $unsigned($random(seed)) % 127);
        final_report();
    end
endmodule
